//--- dv/maintenance_bit_filter_bench.sv
/*
 * Self-checking bench for the maintenance bit filter: register reads,
 * transmit muxing, Field_a modes, report mask and EOC modes.
 * Assumes the controller model collects monitor messages.
 */
`timescale 1ns/10ps
module maintenance_bit_filter_bench;
    import mbf_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    mbf_rx_t [3:0] rx_i;
    logic [3:0] deact_state_i = 4'h0;
    logic [3:0] eoc_sent_i = 4'h0;
    logic [11:0] eoc_tx_i [4];
    logic [7:0] sm_m4_i [4];
    logic [7:0] ctl_m4_i [4];
    logic [3:0] feb_cnt_i = 4'h0;
    logic [3:0] feb_ctl_i = 4'h0;
    logic [7:0] tx_m4_o [4];
    logic [7:0] sm_m4_o [4];
    logic [3:0] feb_o;
    mbf_mon_t mon_o;
    mbf_mon_t last;
    int msg_cnt;
    int error_cnt = 0;
    int n_compared = 0;
    logic [7:0] v;
    logic [7:0] d;
    logic [11:0] e;

    always #25 mclk_i = ~mclk_i;

    mbf_filter DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_i(rx_i), .deact_state_i(deact_state_i), .eoc_sent_i(eoc_sent_i),
        .eoc_tx_i(eoc_tx_i), .sm_m4_i(sm_m4_i), .ctl_m4_i(ctl_m4_i),
        .feb_cnt_i(feb_cnt_i), .feb_ctl_i(feb_ctl_i), .tx_m4_o(tx_m4_o),
        .feb_o(feb_o), .sm_m4_o(sm_m4_o), .mon_o(mon_o));
    mbf_ctl_model ctl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mon_i(mon_o),
        .msg_cnt_o(msg_cnt), .last_o(last));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected value at %0t: got %h exp %h",
                $time, got, exp);
        end
    endtask

    function logic [7:0] tx_exp(logic [7:0] sm, logic [7:0] c, logic [7:0] m);
        return (sm & ~m) | (c & m);
    endfunction

    task wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= dat;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        dat = rdata_o;
    endtask

    // Filter written only while the ports sit deactivated
    task set_filter(input logic [7:0] f);
        @(posedge mclk_i);
        deact_state_i <= 4'hf;
        wr(MBF_OFF_FILT, f);
        @(posedge mclk_i);
        deact_state_i <= 4'h0;
        @(posedge mclk_i);
    endtask

    // One receive event, then count messages and check the last one
    task evc(input int p, input logic fr, input logic sf, input logic ok,
             input logic [7:0] m, input logic ev, input logic [11:0] ee,
             input int n);
        int c0;
        logic [15:0] ex;
        c0 = msg_cnt;
        ex = {1'b0, 2'(p), ev, ev ? ee : {4'h0, m}};
        @(posedge mclk_i);
        rx_i[p].frame <= fr;
        rx_i[p].sf_end <= sf;
        rx_i[p].crc_ok <= ok;
        rx_i[p].eoc_vld <= ev;
        if (fr) rx_i[p].m4 <= m;
        if (ev) rx_i[p].eoc <= ee;
        @(posedge mclk_i);
        rx_i[p].frame <= 1'b0;
        rx_i[p].sf_end <= 1'b0;
        rx_i[p].eoc_vld <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk(16'(msg_cnt - c0), 16'(n));
        if (n > 0) chk({1'b0, last.port, last.is_eoc, last.data}, ex);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rx_i = '0;
        foreach (sm_m4_i[p]) begin
            rx_i[p].m4 = 8'hff;
            rx_i[p].spare = 3'h7;
            sm_m4_i[p] = 8'h00;
            ctl_m4_i[p] = 8'h00;
            eoc_tx_i[p] = 12'h000;
        end
        void'($urandom(81416));
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        // Reset values and an unmapped place
        rd(8'h00, d);
        chk(d, 8'h02);
        rd(8'h01, d);
        chk(d, 8'h14);
        rd(8'h07, d);
        chk(d, 8'h00);
        rd(8'h08, d);
        chk(d, 8'hbc);
        rd(8'h05, d);
        chk(d, 8'h00);
        $display("test reset values done");
        // State machine path: triple-look by default, bit 6 forcing
        evc(1, 1, 0, 0, 8'hbf, 0, 0, 0);
        evc(1, 1, 0, 0, 8'hbf, 0, 0, 0);
        chk(sm_m4_o[1], 8'hff);
        evc(1, 1, 0, 0, 8'hbf, 0, 0, 0);
        chk(sm_m4_o[1], 8'hbf);
        wr(MBF_OFF_TMASK, 8'h40);
        repeat (2) @(posedge mclk_i);
        #1;
        chk(sm_m4_o[1][6], 1'b1);
        $display("test state machine path done");
        // Transmit source mux and far block error source
        repeat (8) begin
            v = 8'($urandom);
            @(posedge mclk_i);
            foreach (sm_m4_i[p]) begin
                sm_m4_i[p] <= 8'($urandom);
                ctl_m4_i[p] <= 8'($urandom);
            end
            feb_cnt_i <= 4'($urandom);
            feb_ctl_i <= 4'($urandom);
            wr(MBF_OFF_TMASK, v);
            foreach (tx_m4_o[p]) chk(tx_m4_o[p],
                tx_exp(sm_m4_i[p], ctl_m4_i[p], v));
            chk(feb_o, feb_cnt_i);
            wr(MBF_OFF_OPMODE, 8'h22);
            chk(feb_o, feb_ctl_i);
            rd(MBF_OFF_TMASK, d);
            chk(d, v);
            wr(MBF_OFF_OPMODE, 8'h02);
        end
        wr(MBF_OFF_TMASK, 8'hbc);
        $display("test transmit sources done");
        // Triple-look reporting on port 2 after one global write
        set_filter(8'h48);
        v = 8'($urandom_range(0, 254));
        evc(2, 1, 0, 0, v, 0, 0, 0);
        evc(2, 1, 0, 0, v ^ 8'h01, 0, 0, 0);
        evc(2, 1, 0, 0, v, 0, 0, 0);
        evc(2, 1, 0, 0, v, 0, 0, 0);
        evc(2, 1, 0, 0, v, 0, 0, 1);
        $display("test triple look done");
        // On-change with the report mask
        set_filter(8'h40);
        evc(0, 1, 0, 0, v, 0, 0, 1);
        evc(0, 1, 0, 0, v, 0, 0, 0);
        wr(MBF_OFF_RMASK, 8'h01);
        evc(0, 1, 0, 0, v ^ 8'h01, 0, 0, 0);
        wr(MBF_OFF_RMASK, 8'h00);
        evc(0, 1, 0, 0, v ^ 8'h01, 0, 0, 0);
        // Filter written while deactivated waits until the port leaves
        @(posedge mclk_i);
        deact_state_i <= 4'hf;
        wr(MBF_OFF_FILT, 8'h48);
        evc(0, 1, 0, 0, v, 0, 0, 1);
        set_filter(8'h48);
        evc(0, 1, 0, 0, v ^ 8'h02, 0, 0, 0);
        // State machine path follows the report filter when bit 5 set
        set_filter(8'h60);
        evc(1, 1, 0, 0, 8'h3c, 0, 0, 1);
        chk(sm_m4_o[1], 8'h3c);
        $display("test on change done");
        // CRC hold for one superframe
        set_filter(8'h50);
        evc(0, 1, 0, 0, v ^ 8'h5a, 0, 0, 0);
        evc(0, 0, 1, 1, v ^ 8'h5a, 0, 0, 0);
        evc(0, 0, 1, 1, v ^ 8'h5a, 0, 0, 1);
        evc(0, 1, 0, 0, v ^ 8'ha5, 0, 0, 0);
        evc(0, 0, 1, 1, v ^ 8'ha5, 0, 0, 0);
        evc(0, 0, 1, 0, v ^ 8'ha5, 0, 0, 0);
        // Combined mode: three frames, then three clean superframes
        set_filter(8'h58);
        repeat (3) evc(0, 1, 0, 0, v ^ 8'h33, 0, 0, 0);
        repeat (3) evc(0, 0, 1, 1, v ^ 8'h33, 0, 0, 0);
        evc(0, 0, 1, 1, v ^ 8'h33, 0, 0, 1);
        $display("test crc done");
        // EOC modes
        e = 12'($urandom) | 12'h800;
        set_filter(8'h41);
        evc(3, 0, 0, 0, 0, 1, e, 1);
        evc(3, 0, 0, 0, 0, 1, e, 1);
        set_filter(8'h42);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h001, 1);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h001, 0);
        set_filter(8'h43);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h010, 0);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h010, 0);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h010, 1);
        set_filter(8'h44);
        @(posedge mclk_i);
        eoc_tx_i[3] <= e ^ 12'h020;
        eoc_sent_i <= 4'h8;
        @(posedge mclk_i);
        eoc_sent_i <= 4'h0;
        repeat (2) evc(3, 0, 0, 0, 0, 1, e ^ 12'h020, 0);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h020, 1);
        repeat (2) evc(3, 0, 0, 0, 0, 1, e ^ 12'h100, 0);
        repeat (2) evc(3, 0, 0, 0, 0, 1, e ^ 12'h020, 0);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h020, 1);
        repeat (2) evc(3, 0, 0, 0, 0, 1, e ^ 12'h100, 0);
        evc(3, 0, 0, 0, 0, 1, e ^ 12'h100, 1);
        repeat (2) evc(3, 0, 0, 0, 0, 1, e ^ 12'h200, 0);
        repeat (3) evc(3, 0, 0, 0, 0, 1, e ^ 12'h100, 0);
        $display("test eoc done");
        end_of_test();
    end
endmodule

//--- dv/mbf_ctl_model.sv
/*
 * Controller-side model: takes monitor messages from the filter, counts
 * them and keeps the last one for the bench to inspect.
 * Assumes mon_i is a one-cycle message strobe on mclk_i.
 */
`timescale 1ns/10ps
module mbf_ctl_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Monitor messages in
    input wire mbf_pkg::mbf_mon_t mon_i,
    // Collected results
    output int msg_cnt_o,
    output mbf_pkg::mbf_mon_t last_o
);
    import mbf_pkg::*;

    // Count and keep every message offered
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msg_cnt_o <= 0;
            last_o <= '0;
        end else if (mon_i.vld) begin
            msg_cnt_o <= msg_cnt_o + 1;
            last_o <= mon_i;
        end
    end
endmodule

//--- src/mbf_filter.sv
/*
 * Maintenance bit filter for four line ports: validates received M4,
 * spare and EOC bits, issues monitor messages and selects the source of
 * each transmitted M4 bit.
 * Assumes per-port frame strobes on mclk_i and an arbiter that accepts
 * one monitor message per cycle.
 */
`timescale 1ns/10ps
module mbf_filter (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Per-port receive and state
    input wire mbf_pkg::mbf_rx_t [3:0] rx_i,
    input wire logic [3:0] deact_state_i,
    input wire logic [3:0] eoc_sent_i,
    input wire logic [11:0] eoc_tx_i [4],
    // Transmit M4 sources
    input wire logic [7:0] sm_m4_i [4],
    input wire logic [7:0] ctl_m4_i [4],
    input wire logic [3:0] feb_cnt_i,
    input wire logic [3:0] feb_ctl_i,
    // Outputs
    output logic [7:0] tx_m4_o [4],
    output logic [3:0] feb_o,
    output logic [7:0] sm_m4_o [4],
    output mbf_pkg::mbf_mon_t mon_o
);
    import mbf_pkg::*;

    // ---------------------------------------------------------------
    // Global registers
    // ---------------------------------------------------------------
    logic [7:0] opmode_q, filt_q, rmask_q, tmask_q;
    logic [7:0] rdata_d;

    // Register writes; all global across ports
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opmode_q <= MBF_RST_OPMODE;
            filt_q <= MBF_RST_FILT;
            rmask_q <= MBF_RST_RMASK;
            tmask_q <= MBF_RST_TMASK;
        end else if (wr_i) begin
            case (addr_i)
                MBF_OFF_OPMODE: opmode_q <= wdata_i;
                MBF_OFF_FILT: filt_q <= wdata_i;
                MBF_OFF_RMASK: rmask_q <= wdata_i;
                MBF_OFF_TMASK: tmask_q <= wdata_i;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    logic [3:0] deact_live;
    always_comb begin
        case (addr_i)
            MBF_OFF_OPMODE: rdata_d = opmode_q;
            MBF_OFF_FILT: rdata_d = filt_q;
            MBF_OFF_RMASK: rdata_d = rmask_q;
            MBF_OFF_TMASK: rdata_d = tmask_q;
            MBF_OFF_STATUS: rdata_d = {4'h0, deact_live};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rdata_d : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Per-port filters
    // ---------------------------------------------------------------
    logic [3:0] m4_ev, eoc_ev;
    logic [7:0] m4_rep [4];
    logic [11:0] eoc_rep [4];

    genvar p;
    generate
        for (p = 0; p < MBF_NPORT; p++) begin : g_port
            logic [7:0] act_filt_q;       // Sampled filter setting
            logic deact_q;
            logic [10:0] cand_q, acc_q;   // M4 + spare candidate/accepted
            logic [1:0] tll_q;
            logic [10:0] crc_hold_q;      // Value held for CRC check
            logic crc_pend_q;
            logic [1:0] sf_ok_q;
            logic [7:0] sm_q;
            logic [11:0] ecand_q, eacc_q, eprev_q;
            logic [1:0] etll_q;
            logic [11:0] ecmd_q;
            logic ecmd_vld_q;
            logic [10:0] rx_v;
            logic tll_hit, crc_use, tll_use;
            logic [10:0] sel_tll, sel_crc, sel_new, acc_d;
            logic [10:0] chg;
            logic [1:0] m4_mode;
            logic e_tll_ok, e_fire;

            assign rx_v = {rx_i[p].spare, rx_i[p].m4};
            assign m4_mode = act_filt_q[4:3];
            assign deact_live[p] = deact_q;

            // Sample filter on leaving deactivated state
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    act_filt_q <= MBF_RST_FILT;
                    deact_q <= 1'b1;
                end else begin
                    deact_q <= deact_state_i[p];
                    if (deact_q && !deact_state_i[p]) begin
                        act_filt_q <= filt_q;
                    end
                end
            end

            // Triple-look: counts consecutive identical frames
            assign tll_hit = rx_i[p].frame && (rx_v == cand_q)
                && (tll_q == 2'(MBF_TLL_CNT - 2));
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cand_q <= 11'h000;
                    tll_q <= 2'h0;
                end else if (rx_i[p].frame) begin
                    if (rx_v != cand_q) begin
                        cand_q <= rx_v;
                        tll_q <= 2'h0;
                    end else if (tll_q != 2'h3) begin
                        tll_q <= tll_q + 2'h1;
                    end
                end
            end

            // CRC hold: value captured at superframe end, released on next
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    crc_hold_q <= 11'h000;
                    crc_pend_q <= 1'b0;
                    sf_ok_q <= 2'h0;
                end else if (rx_i[p].sf_end) begin
                    crc_hold_q <= (m4_mode == MBF_M4_BOTH) ? cand_q : rx_v;
                    crc_pend_q <= 1'b1;
                    if (!rx_i[p].crc_ok) begin
                        sf_ok_q <= 2'h0;
                    end else if (sf_ok_q != 2'(MBF_SF_CNT)) begin
                        sf_ok_q <= sf_ok_q + 2'h1;
                    end
                end
            end

            // Per-mode selection of validated value
            assign crc_use = rx_i[p].sf_end && crc_pend_q && rx_i[p].crc_ok;
            always_comb begin
                sel_tll = tll_hit ? cand_q : acc_q;
                sel_crc = crc_use ? crc_hold_q : acc_q;
                case (m4_mode)
                    MBF_M4_CHG: sel_new = rx_i[p].frame ? rx_v
                        : acc_q;
                    MBF_M4_TLL: sel_new = sel_tll;
                    MBF_M4_CRC: sel_new = sel_crc;
                    MBF_M4_BOTH: sel_new = (sf_ok_q == 2'(MBF_SF_CNT)
                        && tll_q >= 2'(MBF_TLL_CNT - 1))
                        ? sel_crc : acc_q;
                    default: sel_new = acc_q;
                endcase
                acc_d = sel_new;
                if (act_filt_q[MBF_SPARE_POS] && rx_i[p].frame) begin
                    acc_d[10:8] = rx_v[10:8];
                end
            end
            assign chg = acc_d ^ acc_q;

            // Accepted value; masked changes still update it
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    acc_q <= 11'h7ff;
                end else begin
                    acc_q <= acc_d;
                end
            end
            assign m4_ev[p] = |{chg[10:8], chg[7:0] & ~rmask_q};
            assign m4_rep[p] = acc_d[7:0];

            // M4 toward state machine; bit 6 forces S-activity high
            assign tll_use = !act_filt_q[MBF_SM_SEL_POS];
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sm_q <= 8'hff;
                end else begin
                    sm_q <= tll_use ? (tll_hit ? cand_q[7:0] : sm_q)
                        : acc_d[7:0];
                end
            end
            assign sm_m4_o[p] = {sm_q[7], sm_q[6] | tmask_q[MBF_UOA_POS],
                sm_q[5:0]};

            // EOC filtering
            assign e_tll_ok = rx_i[p].eoc_vld && rx_i[p].eoc == ecand_q
                && etll_q == 2'(MBF_TLL_CNT - 2);
            always_comb begin
                case (act_filt_q[2:0])
                    MBF_EOC_TRANS: e_fire = rx_i[p].eoc_vld;
                    MBF_EOC_CHG: e_fire = rx_i[p].eoc_vld
                        && rx_i[p].eoc != eprev_q;
                    MBF_EOC_TLL: e_fire = e_tll_ok
                        && ecand_q != eacc_q;
                    MBF_EOC_AUTO: e_fire = e_tll_ok
                        && ((ecmd_vld_q && ecand_q == ecmd_q)
                        || ecand_q != eacc_q);
                    default: e_fire = 1'b0;
                endcase
            end
            assign eoc_ev[p] = e_fire;
            assign eoc_rep[p] = rx_i[p].eoc;

            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ecand_q <= 12'h000;
                    etll_q <= 2'h0;
                    eacc_q <= 12'h000;
                    eprev_q <= 12'h000;
                    ecmd_q <= 12'h000;
                    ecmd_vld_q <= 1'b0;
                end else begin
                    if (eoc_sent_i[p]) begin
                        ecmd_q <= eoc_tx_i[p];
                        ecmd_vld_q <= 1'b1;
                    end
                    if (rx_i[p].eoc_vld) begin
                        eprev_q <= rx_i[p].eoc;
                        if (rx_i[p].eoc != ecand_q) begin
                            ecand_q <= rx_i[p].eoc;
                            etll_q <= 2'h0;
                        end else if (etll_q != 2'h3) begin
                            etll_q <= etll_q + 2'h1;
                        end
                        if (e_tll_ok) begin
                            eacc_q <= ecand_q;
                        end
                    end
                end
            end

            // Transmit M4 source per bit
            assign tx_m4_o[p] = (sm_m4_i[p] & ~tmask_q)
                | (ctl_m4_i[p] & tmask_q);
            assign feb_o[p] = opmode_q[MBF_FEB_POS] ? feb_ctl_i[p]
                : feb_cnt_i[p];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Monitor message issue, lowest port and EOC first
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon_o <= '0;
        end else begin
            mon_o <= '0;
            for (int i = MBF_NPORT - 1; i >= 0; i--) begin
                if (m4_ev[i]) begin
                    mon_o <= '{1'b1, 2'(i), 1'b0, {4'h0, m4_rep[i]}};
                end
                if (eoc_ev[i]) begin
                    mon_o <= '{1'b1, 2'(i), 1'b1, eoc_rep[i]};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_feb_src: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        opmode_q[MBF_FEB_POS] |-> feb_o == feb_ctl_i)
        else $error("far block error source wrong");
    chk_tx_source: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        tx_m4_o[0] == ((sm_m4_i[0] & ~tmask_q) | (ctl_m4_i[0] & tmask_q)))
        else $error("tx m4 source wrong");
    chk_sai_force: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        tmask_q[MBF_UOA_POS] |-> sm_m4_o[0][6])
        else $error("s activity not forced");
    chk_filt_global: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        wr_i && addr_i == MBF_OFF_FILT |=> filt_q == $past(wdata_i))
        else $error("filter write lost");
    chk_filt_sample: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !deact_state_i[0] && !g_port[0].deact_q
        |=> $stable(g_port[0].act_filt_q))
        else $error("filter changed while active");
    chk_rd_latency: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == MBF_OFF_RMASK |=> rdata_o == $past(rmask_q))
        else $error("read data wrong");
    chk_eoc_trans: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        g_port[0].act_filt_q[2:0] == MBF_EOC_TRANS && rx_i[0].eoc_vld
        |-> eoc_ev[0])
        else $error("transparent eoc dropped");
    chk_mask_upd: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        g_port[0].m4_mode == MBF_M4_CHG && rx_i[0].frame
        |=> g_port[0].acc_q[7:0] == $past(rx_i[0].m4))
        else $error("accepted m4 not updated");
    cov_m4_msg: cover property (@(posedge mclk_i)
        mon_o.vld && !mon_o.is_eoc);
    cov_eoc_msg: cover property (@(posedge mclk_i)
        mon_o.vld && mon_o.is_eoc);
    cov_leave: cover property (@(posedge mclk_i) g_port[0].deact_q
        && !deact_state_i[0]);
endmodule

//--- src/mbf_pkg.sv
/*
 * Package for the maintenance bit filter: register map, field positions,
 * reset values, filter mode encodings and carrier structs.
 * Assumes a single 20 MHz device clock shared by all users of the block.
 */
package mbf_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] MBF_OFF_OPMODE = 8'h00;
    localparam logic [7:0] MBF_OFF_FILT = 8'h01;
    localparam logic [7:0] MBF_OFF_RMASK = 8'h07;
    localparam logic [7:0] MBF_OFF_TMASK = 8'h08;
    localparam logic [7:0] MBF_OFF_STATUS = 8'h20;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] MBF_RST_OPMODE = 8'h02;
    localparam logic [7:0] MBF_RST_FILT = 8'h14;
    localparam logic [7:0] MBF_RST_RMASK = 8'h00;
    localparam logic [7:0] MBF_RST_TMASK = 8'hbc;
    // ---------------------------------------------------------------
    // Field positions and counts
    // ---------------------------------------------------------------
    localparam int MBF_FEB_POS = 5;
    localparam int MBF_SM_SEL_POS = 5;
    localparam int MBF_SPARE_POS = 6;
    localparam int MBF_UOA_POS = 6;
    localparam int MBF_NPORT = 4;
    localparam int MBF_TLL_CNT = 3;
    localparam int MBF_SF_CNT = 3;
    // Field_a codes (bits 4:3)
    localparam logic [1:0] MBF_M4_CHG = 2'h0;
    localparam logic [1:0] MBF_M4_TLL = 2'h1;
    localparam logic [1:0] MBF_M4_CRC = 2'h2;
    localparam logic [1:0] MBF_M4_BOTH = 2'h3;
    // EOC filter codes (bits 2:0)
    localparam logic [2:0] MBF_EOC_AUTO = 3'h4;
    localparam logic [2:0] MBF_EOC_TRANS = 3'h1;
    localparam logic [2:0] MBF_EOC_CHG = 3'h2;
    localparam logic [2:0] MBF_EOC_TLL = 3'h3;

    // Received frame info for one port
    typedef struct packed {
        logic frame;      // One U-frame received
        logic sf_end;     // Superframe end, crc_ok valid
        logic crc_ok;     // CRC of superframe just ended clean
        logic [7:0] m4;   // Received M4 bits
        logic [2:0] spare; // Received M5/M6 spare bits
        logic eoc_vld;    // EOC message complete (every 6 ms)
        logic [11:0] eoc; // EOC message
    } mbf_rx_t;

    // Monitor message out
    typedef struct packed {
        logic vld;
        logic [1:0] port;
        logic is_eoc;       // 1 = eoc_monitor_msg, 0 = mbit_monitor_msg
        logic [11:0] data;
    } mbf_mon_t;
endpackage
